// ===== rtl/afe_spi_ctrl.sv
// Serial port slave with handshake, streaming and data-ready control.
// Behaviour
// - Driver select picks serial out, ready or high-Z on the shared pin.
// - Trigger bit 0: serial out goes high-Z after the last rising edge.
// - Trigger bit 1: high-Z waits for chip select to deassert.
// - Stream register bit 7 selects normal (0) or controlled (1) streaming.
// - Streaming register bits 6..0 hold the controlled span, reset zero.
// - Data-only start address is seven bits, resets to 0x1A, bit 7 reserved.
// - Data-only size field gives byte count minus one, default 0x2.
// - Ready control bit 7 puts the ready signal on pin six.
// - Ready control bit 5 clear resets the CRC when ready deasserts.
// - Ready control bit 3 selects the amplifier gain calibration method.
// - Ready deasserts high once the result low byte has been read.
`timescale 1ns/1ps
`default_nettype none
module afe_spi_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic sdi,
    input wire logic conv_valid,
    input wire logic [15:0] conv_result,
    input wire logic gpio_six_out,
    input wire logic gpio_six_oe_n,
    output logic sdo_out,
    output logic sdo_oe_n,
    output logic general_pin_six_out,
    output logic general_pin_six_oe_n,
    output logic conversion_ready_n,
    output logic crc_clear,
    output logic amp_gain_calibration_select,
    output logic stream_kind,
    output logic [afe_spi_pkg::ADDR_W-1:0] controlled_stream_span,
    output logic [afe_spi_pkg::ADDR_W-1:0] data_only_start,
    output logic [2:0] result_read_byte_count
);
    import afe_spi_pkg::*;

    logic [2:0] pins_s;
    logic sclk_s, cs_n_s, sdi_s, sclk_prev_q;
    logic rise, fall, cs_on;
    frame_e frame_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q, tx_q, rx_byte, rd_data;
    logic read_q, byte_done, reading_result, sdo_active_q, tx_bit_q;
    logic [ADDR_W-1:0] addr_q, base_q, span_cnt_q, next_addr, rd_addr;
    logic [7:0] handshake_q, stream_q, donly_start_q, donly_len_q;
    logic [7:0] ready_ctl_q;
    logic [15:0] result_q;
    logic ready_n_q, ready_rise, low_byte_read;
    logic [2:0] drv_sel;
    logic pin_drive, pin_level;

    // Pins from the host cross into the core clock first; idle high.
    pin_sync #(.WIDTH(3), .INIT(3'h7)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin({sclk, chip_select_n, sdi}),
        .sync(pins_s)
    );
    assign {sclk_s, cs_n_s, sdi_s} = pins_s;

    // Edge detection works on the synchronised clock only.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end
    assign rise = sclk_s & ~sclk_prev_q;
    assign fall = ~sclk_s & sclk_prev_q;
    assign cs_on = ~cs_n_s;
    assign byte_done = cs_on & rise & (bit_cnt_q == LAST_BIT);
    assign rx_byte = {rx_q[6:0], sdi_s};

    // Receive shifter and bit counter; a byte ends on its eighth rising edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_q <= 8'h00;
            bit_cnt_q <= 3'h0;
        end else if (!cs_on) begin
            bit_cnt_q <= 3'h0;
        end else if (rise) begin
            rx_q <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // Frame sequencer: one instruction byte, then data bytes until deselect.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_q <= FRAME_IDLE;
            read_q <= 1'b0;
        end else if (!cs_on) begin
            frame_q <= FRAME_IDLE;
            read_q <= 1'b0;
        end else begin
            unique case (frame_q)
                FRAME_IDLE: begin
                    frame_q <= FRAME_INSTR;
                end
                FRAME_INSTR: begin
                    if (byte_done) begin
                        frame_q <= FRAME_DATA;
                        read_q <= (rx_byte[7] == READ_CMD);
                    end
                end
                FRAME_DATA: begin
                    frame_q <= FRAME_DATA;
                end
                default: begin
                    frame_q <= FRAME_IDLE;
                end
            endcase
        end
    end

    // Controlled streaming wraps back to the base after span+1 bytes.
    always_comb begin
        next_addr = addr_q + 7'h01;
        if (stream_q[STREAM_KIND_BIT] &&
            span_cnt_q == stream_q[ADDR_W-1:0]) begin
            next_addr = base_q;
        end
    end

    // Address pointer: loaded by the instruction, stepped by each data byte.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= 7'h00;
            base_q <= 7'h00;
            span_cnt_q <= 7'h00;
        end else if (byte_done && frame_q == FRAME_INSTR) begin
            addr_q <= rx_byte[ADDR_W-1:0];
            base_q <= rx_byte[ADDR_W-1:0];
            span_cnt_q <= 7'h00;
        end else if (byte_done && frame_q == FRAME_DATA) begin
            addr_q <= next_addr;
            span_cnt_q <= (next_addr == base_q) ? 7'h00 : span_cnt_q + 7'h01;
        end
    end

    // Register writes land when a data byte of a write frame completes.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            handshake_q <= RST_HANDSHAKE;
            stream_q <= RST_STREAM;
            donly_start_q <= RST_DONLY_START;
            donly_len_q <= RST_DONLY_LEN;
            ready_ctl_q <= RST_READY_CTL;
        end else if (byte_done && frame_q == FRAME_DATA && !read_q) begin
            unique case (addr_q)
                OFS_HANDSHAKE: handshake_q <= rx_byte & MASK_HANDSHAKE;
                OFS_STREAM: stream_q <= rx_byte;
                OFS_DONLY_START: donly_start_q <= rx_byte & MASK_DONLY_START;
                OFS_DONLY_LEN: donly_len_q <= rx_byte & MASK_DONLY_LEN;
                // Low bits are stored as written; software must keep 0x3.
                OFS_READY_CTL: ready_ctl_q <= rx_byte & MASK_READY_CTL;
                default: begin
                end
            endcase
        end
    end

    // Read data mux; the instruction byte fetches its own address, later
    // bytes the next one. Unmapped addresses read as zero.
    assign rd_addr = (frame_q == FRAME_INSTR) ?
        rx_byte[ADDR_W-1:0] : next_addr;
    always_comb begin
        unique case (rd_addr)
            OFS_HANDSHAKE: rd_data = handshake_q;
            OFS_STREAM: rd_data = stream_q;
            OFS_DONLY_START: rd_data = donly_start_q;
            OFS_DONLY_LEN: rd_data = donly_len_q;
            OFS_READY_CTL: rd_data = ready_ctl_q;
            OFS_RESULT_HIGH: rd_data = result_q[15:8];
            OFS_RESULT_LOW: rd_data = result_q[7:0];
            default: rd_data = 8'h00;
        endcase
    end

    // Transmit shifter: loaded at a byte boundary, shifted on falling edges.
    // Loading at every byte end has the next byte ready before its fall.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_q <= 8'h00;
        end else if (byte_done) begin
            tx_q <= rd_data;
        end else if (cs_on && fall && frame_q == FRAME_DATA && read_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Result is frozen while a frame is open so both bytes belong together.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_q <= 16'h0000;
        end else if (conv_valid && !cs_on) begin
            result_q <= conv_result;
        end
    end

    // Serial out drives from the first falling edge of a read byte. With
    // trigger 0 it lets go on the byte's last rising edge, giving the host
    // time to take the line; with trigger 1 it holds until deselect.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdo_active_q <= 1'b0;
            tx_bit_q <= 1'b1;
        end else if (!cs_on) begin
            sdo_active_q <= 1'b0;
        end else if (byte_done && !handshake_q[TRIG_BIT]) begin
            sdo_active_q <= 1'b0;
        end else if (fall && frame_q == FRAME_DATA && read_q) begin
            sdo_active_q <= 1'b1;
            tx_bit_q <= tx_q[7];
        end
    end

    assign reading_result = read_q && frame_q == FRAME_DATA &&
        (addr_q == OFS_RESULT_HIGH || addr_q == OFS_RESULT_LOW);
    assign low_byte_read = byte_done && frame_q == FRAME_DATA && read_q &&
        addr_q == OFS_RESULT_LOW;
    assign ready_rise = low_byte_read && !ready_n_q && !conv_valid;

    // Ready goes low on a new result; reading the low byte raises it.
    // A new result in the same cycle wins and keeps ready low; result_q does not take it while selected.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ready_n_q <= 1'b1;
            crc_clear <= 1'b0;
        end else begin
            if (conv_valid) begin
                ready_n_q <= 1'b0;
            end else if (low_byte_read) begin
                ready_n_q <= 1'b1;
            end
            crc_clear <= ready_rise && !ready_ctl_q[CRC_KEEP_BIT];
        end
    end
    assign conversion_ready_n = ready_n_q;

    // Shared pin source per driver select; forbidden codes act as 0x0.
    assign drv_sel = handshake_q[DRV_LSB+2:DRV_LSB];
    always_comb begin
        pin_drive = 1'b0;
        pin_level = 1'b1;
        if (cs_on && reading_result) begin
            pin_drive = sdo_active_q;
            pin_level = tx_bit_q;
        end else if (cs_on && read_q && frame_q == FRAME_DATA) begin
            pin_drive = sdo_active_q;
            pin_level = tx_bit_q;
        end else if (cs_on && drv_sel != DRV_DATA_ONLY) begin
            pin_drive = 1'b1;
            pin_level = ready_n_q;
        end else if (!cs_on && drv_sel == DRV_READY_ALWAYS) begin
            pin_drive = 1'b1;
            pin_level = ready_n_q;
        end
    end

    // Pin and configuration outputs leave from flip-flops.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdo_oe_n <= 1'b1;
            sdo_out <= 1'b1;
            general_pin_six_out <= 1'b1;
            general_pin_six_oe_n <= 1'b1;
            amp_gain_calibration_select <= 1'b0;
            stream_kind <= 1'b0;
            controlled_stream_span <= 7'h00;
            data_only_start <= RST_DONLY_START[ADDR_W-1:0];
            result_read_byte_count <= RST_DONLY_LEN[2:0];
        end else begin
            sdo_oe_n <= ~pin_drive;
            sdo_out <= pin_level;
            if (ready_ctl_q[PIN_SIX_BIT]) begin
                general_pin_six_out <= ready_n_q;
                general_pin_six_oe_n <= 1'b0;
            end else begin
                general_pin_six_out <= gpio_six_out;
                general_pin_six_oe_n <= gpio_six_oe_n;
            end
            amp_gain_calibration_select <= ready_ctl_q[GAIN_CAL_BIT];
            stream_kind <= stream_q[STREAM_KIND_BIT];
            controlled_stream_span <= stream_q[ADDR_W-1:0];
            data_only_start <= donly_start_q[ADDR_W-1:0];
            result_read_byte_count <= donly_len_q[2:0];
        end
    end

    a_ready_on_read: assert property (@(posedge clk) disable iff (!nrst)
        low_byte_read && !conv_valid |=> conversion_ready_n)
        else $error("ready did not deassert after low byte read");
    a_ready_on_conv: assert property (@(posedge clk) disable iff (!nrst)
        conv_valid |=> !conversion_ready_n ##0 !crc_clear)
        else $error("new result did not assert ready");
    a_crc_clear_pulse: assert property (@(posedge clk) disable iff (!nrst)
        crc_clear |-> $rose(conversion_ready_n) &&
        !$past(ready_ctl_q[CRC_KEEP_BIT]))
        else $error("crc clear without ready deassertion");
    a_crc_clear_due: assert property (@(posedge clk) disable iff (!nrst)
        ready_rise && !ready_ctl_q[CRC_KEEP_BIT] |=> crc_clear)
        else $error("crc clear missing on ready deassertion");
    a_release_early: assert property (@(posedge clk) disable iff (!nrst)
        byte_done && !handshake_q[TRIG_BIT] |=> !sdo_active_q)
        else $error("serial out not released after last rising edge");
    a_release_held: assert property (@(posedge clk) disable iff (!nrst)
        byte_done && handshake_q[TRIG_BIT] && sdo_active_q
        |=> sdo_active_q)
        else $error("serial out released before the falling edge");
    a_deselect_hiz: assert property (@(posedge clk) disable iff (!nrst)
        !cs_on && drv_sel == DRV_NORMAL |=> sdo_oe_n)
        else $error("pin driven while deselected in default mode");
    a_ready_always: assert property (@(posedge clk) disable iff (!nrst)
        !cs_on && drv_sel == DRV_READY_ALWAYS
        |=> !sdo_oe_n && sdo_out == $past(ready_n_q))
        else $error("ready not driven while deselected");
    a_data_only_hiz: assert property (@(posedge clk) disable iff (!nrst)
        cs_on && drv_sel == DRV_DATA_ONLY && frame_q != FRAME_DATA
        |=> sdo_oe_n)
        else $error("pin driven outside a read in mode 0x4");
    a_pin_six_ready: assert property (@(posedge clk) disable iff (!nrst)
        ready_ctl_q[PIN_SIX_BIT] |=> !general_pin_six_oe_n &&
        general_pin_six_out == $past(conversion_ready_n))
        else $error("ready not routed to pin six");
    a_gain_cal_follow: assert property (@(posedge clk) disable iff (!nrst)
        ##1 amp_gain_calibration_select == $past(ready_ctl_q[GAIN_CAL_BIT]))
        else $error("gain calibration select out of step");
endmodule : afe_spi_ctrl
`default_nettype wire

// ===== rtl/afe_spi_pkg.sv
// Constants shared by the serial port control logic of the sensor front end.
package afe_spi_pkg;
    localparam int ADDR_W = 7;
    localparam logic [6:0] OFS_HANDSHAKE = 7'h01;
    localparam logic [6:0] OFS_STREAM = 7'h03;
    localparam logic [6:0] OFS_DONLY_START = 7'h09;
    localparam logic [6:0] OFS_DONLY_LEN = 7'h0A;
    localparam logic [6:0] OFS_READY_CTL = 7'h11;
    localparam logic [6:0] OFS_RESULT_HIGH = 7'h1A;
    localparam logic [6:0] OFS_RESULT_LOW = 7'h1B;
    localparam logic [7:0] RST_HANDSHAKE = 8'h00;
    localparam logic [7:0] RST_STREAM = 8'h00;
    localparam logic [7:0] RST_DONLY_START = 8'h1A;
    localparam logic [7:0] RST_DONLY_LEN = 8'h02;
    localparam logic [7:0] RST_READY_CTL = 8'h03;
    // Writable bits per register; the rest read as zero.
    localparam logic [7:0] MASK_HANDSHAKE = 8'h0F;
    localparam logic [7:0] MASK_DONLY_START = 8'h7F;
    localparam logic [7:0] MASK_DONLY_LEN = 8'h07;
    localparam logic [7:0] MASK_READY_CTL = 8'hAF;
    localparam int TRIG_BIT = 0;
    localparam int DRV_LSB = 1;
    localparam int STREAM_KIND_BIT = 7;
    localparam int PIN_SIX_BIT = 7;
    localparam int CRC_KEEP_BIT = 5;
    localparam int GAIN_CAL_BIT = 3;
    localparam logic [2:0] DRV_NORMAL = 3'h0;
    localparam logic [2:0] DRV_READY_ALWAYS = 3'h3;
    localparam logic [2:0] DRV_DATA_ONLY = 3'h4;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic READ_CMD = 1'b1;
    typedef enum logic [1:0] {
        FRAME_IDLE = 2'b00,
        FRAME_INSTR = 2'b01,
        FRAME_DATA = 2'b11
    } frame_e;
endpackage : afe_spi_pkg

// ===== rtl/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);
    // Each pin gets its own pair; the first stage feeds only the second.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_q;
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                meta_q <= INIT[i];
                sync[i] <= INIT[i];
            end else begin
                meta_q <= pin[i];
                sync[i] <= meta_q;
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// ===== tb/afe_spi_interface_control_test.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module afe_spi_interface_control_test;
    import afe_spi_pkg::*;
    logic clk, nrst, sclk, chip_select_n, sdi, conv_valid, float_q, sdo_pin;
    logic [15:0] conv_result;
    logic gpio_six_out, gpio_six_oe_n, sdo_out, sdo_oe_n, crc_clear;
    logic general_pin_six_out, general_pin_six_oe_n, conversion_ready_n;
    logic amp_gain_calibration_select, stream_kind;
    logic [ADDR_W-1:0] controlled_stream_span, data_only_start;
    logic [2:0] result_read_byte_count;
    int error_cnt, check_count, crc_pulses;

    // Core clock at 25 MHz.
    initial clk = 1'b0;
    always #20 clk = ~clk;

    // A released pin shows a pattern that changes every cycle, never a hold.
    initial float_q = 1'b0;
    always @(posedge clk) float_q <= ~float_q;
    assign sdo_pin = sdo_oe_n ? float_q : sdo_out;

    // Count checksum clear pulses so a missing or doubled one shows.
    always @(posedge clk) begin
        if (crc_clear === 1'b1) crc_pulses <= crc_pulses + 1;
    end

    afe_spi_ctrl DUT (.clk(clk), .nrst(nrst), .sclk(sclk),
        .chip_select_n(chip_select_n), .sdi(sdi), .conv_valid(conv_valid),
        .conv_result(conv_result), .gpio_six_out(gpio_six_out),
        .gpio_six_oe_n(gpio_six_oe_n), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .general_pin_six_out(general_pin_six_out),
        .general_pin_six_oe_n(general_pin_six_oe_n),
        .conversion_ready_n(conversion_ready_n), .crc_clear(crc_clear),
        .amp_gain_calibration_select(amp_gain_calibration_select),
        .stream_kind(stream_kind),
        .controlled_stream_span(controlled_stream_span),
        .data_only_start(data_only_start),
        .result_read_byte_count(result_read_byte_count));

    spi_host_model HOST (.clk(clk), .sdo_pin(sdo_pin), .sclk(sclk),
        .chip_select_n(chip_select_n), .sdi(sdi));

    task automatic chk_data(input string w, input logic [63:0] e,
                            input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk_data

    task automatic chk_bit(input string w, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", w, e, g);
        end
    endtask : chk_bit

    // One register write frame: instruction byte, then the value.
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] d;
        HOST.select(1'b1);
        HOST.shift_byte({~READ_CMD, a}, d);
        HOST.shift_byte(v, d);
        HOST.select(1'b0);
    endtask : wr

    // Read n bytes in one frame; the first byte lands in the low bits.
    task automatic burst(input logic [6:0] a, input int n,
                         output logic [63:0] q);
        logic [7:0] d;
        q = '0;
        HOST.select(1'b1);
        HOST.shift_byte({READ_CMD, a}, d);
        for (int i = 0; i < n; i++) begin
            HOST.shift_byte(8'h00, d);
            q[8*i +: 8] = d;
        end
        HOST.select(1'b0);
    endtask : burst

    task automatic conv(input logic [15:0] v);
        conv_valid = 1'b1;
        conv_result = v;
        HOST.wait_clk(1);
        conv_valid = 1'b0;
        HOST.wait_clk(2);
    endtask : conv

    task automatic t_reset();
        logic [6:0] ofs[5] = '{OFS_HANDSHAKE, OFS_STREAM, OFS_DONLY_START,
                               OFS_DONLY_LEN, OFS_READY_CTL};
        logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h1A, 8'h02, 8'h03};
        logic [63:0] q;
        chk_data("span", 64'h00, 64'(controlled_stream_span));
        chk_data("start", 64'h1A, 64'(data_only_start));
        chk_data("count", 64'h02, 64'(result_read_byte_count));
        chk_bit("kind", 1'b0, stream_kind);
        chk_bit("gain", 1'b0, amp_gain_calibration_select);
        chk_bit("ready", 1'b1, conversion_ready_n);
        for (int i = 0; i < 5; i++) begin
            burst(ofs[i], 1, q);
            chk_data("reset value", 64'(rv[i]), q);
        end
    endtask : t_reset

    // Normal streaming walks on; controlled streaming folds back.
    task automatic t_stream();
        logic [63:0] q;
        burst(OFS_DONLY_START, 3, q);
        chk_data("normal stream", 64'h00021A, q);
        wr(OFS_STREAM, 8'h81);
        burst(OFS_DONLY_START, 4, q);
        chk_data("span one", 64'h021A021A, q);
        wr(OFS_STREAM, 8'h80);
        burst(OFS_DONLY_START, 3, q);
        chk_data("span zero", 64'h1A1A1A, q);
        wr(OFS_STREAM, 8'h00);
    endtask : t_stream

    task automatic t_regs();
        logic [63:0] q;
        wr(OFS_STREAM, 8'hC5);
        chk_bit("kind set", 1'b1, stream_kind);
        chk_data("span set", 64'h45, 64'(controlled_stream_span));
        wr(OFS_STREAM, 8'h00);
        wr(OFS_DONLY_START, 8'hFF);
        burst(OFS_DONLY_START, 1, q);
        chk_data("start rd", 64'h7F, q);
        chk_data("start port", 64'h7F, 64'(data_only_start));
        wr(OFS_DONLY_LEN, 8'hFF);
        burst(OFS_DONLY_LEN, 1, q);
        chk_data("len rd", 64'h07, q);
        chk_data("len port", 64'h07, 64'(result_read_byte_count));
        wr(OFS_DONLY_LEN, 8'h00);
        chk_data("len one", 64'h00, 64'(result_read_byte_count));
        gpio_six_out = 1'b1;
        gpio_six_oe_n = 1'b1;
        HOST.wait_clk(4);
        chk_bit("six gpio", 1'b1, general_pin_six_oe_n);
        chk_bit("six gpio lvl", 1'b1, general_pin_six_out);
        gpio_six_out = 1'b0;
        wr(OFS_READY_CTL, 8'hFB);
        burst(OFS_READY_CTL, 1, q);
        chk_data("ready ctl rd", 64'hAB, q);
        chk_bit("gain set", 1'b1, amp_gain_calibration_select);
        chk_bit("six drive", 1'b0, general_pin_six_oe_n);
        chk_bit("six level", 1'b1, general_pin_six_out);
        wr(OFS_READY_CTL, 8'h03);
        chk_bit("gain clr", 1'b0, amp_gain_calibration_select);
        wr(7'h7F, 8'h5A);
        burst(7'h7F, 1, q);
        chk_data("unmapped", 64'h00, q);
    endtask : t_regs

    // Ready clears only on the low byte; checksum reset follows bit 5.
    task automatic t_ready();
        logic [63:0] q;
        conv(16'hBEEF);
        chk_bit("ready set", 1'b0, conversion_ready_n);
        crc_pulses = 0;
        burst(OFS_RESULT_HIGH, 1, q);
        chk_data("high", 64'hBE, q);
        chk_bit("ready held", 1'b0, conversion_ready_n);
        burst(OFS_RESULT_LOW, 1, q);
        chk_data("low", 64'hEF, q);
        chk_bit("ready clr", 1'b1, conversion_ready_n);
        chk_data("crc pulse", 64'd1, 64'(crc_pulses));
        wr(OFS_READY_CTL, 8'h23);
        conv(16'h1234);
        crc_pulses = 0;
        burst(OFS_RESULT_HIGH, 2, q);
        chk_data("pair", 64'h3412, q);
        chk_bit("ready clr2", 1'b1, conversion_ready_n);
        chk_data("crc kept", 64'd0, 64'(crc_pulses));
        wr(OFS_READY_CTL, 8'h03);
    endtask : t_ready

    // Each legal driver code, deselected and selected outside a read.
    task automatic t_drive();
        logic [2:0] md[3] = '{DRV_NORMAL, DRV_READY_ALWAYS, DRV_DATA_ONLY};
        logic [63:0] q;
        foreach (md[i]) begin
            wr(OFS_HANDSHAKE, {4'h0, md[i], 1'b0});
            conv(16'h0055);
            chk_bit("desel oe", md[i] != DRV_READY_ALWAYS, sdo_oe_n);
            if (md[i] == DRV_READY_ALWAYS)
                chk_bit("desel lvl", 1'b0, sdo_out);
            HOST.select(1'b1);
            chk_bit("sel oe", md[i] == DRV_DATA_ONLY, sdo_oe_n);
            if (md[i] != DRV_DATA_ONLY)
                chk_bit("sel lvl", 1'b0, sdo_out);
            HOST.select(1'b0);
            burst(OFS_RESULT_LOW, 1, q);
        end
        wr(OFS_HANDSHAKE, 8'h00);
    endtask : t_drive

    // Release point of serial out at the end of a read, per trigger bit.
    task automatic t_release();
        logic [7:0] d;
        for (int t = 0; t < 2; t++) begin
            wr(OFS_HANDSHAKE, {4'h0, DRV_DATA_ONLY, t[0]});
            HOST.select(1'b1);
            HOST.shift_byte({READ_CMD, OFS_HANDSHAKE}, d);
            HOST.shift_byte(8'h00, d);
            chk_data("hs rd", 64'({4'h0, DRV_DATA_ONLY, t[0]}), 64'(d));
            chk_bit("after byte", ~t[0], sdo_oe_n);
            HOST.select(1'b0);
            chk_bit("after desel", 1'b1, sdo_oe_n);
        end
        wr(OFS_HANDSHAKE, 8'h00);
    endtask : t_release

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // Reset for 16 cycles, then run the scenarios in turn.
    initial begin
        nrst = 1'b0;
        conv_valid = 1'b0;
        conv_result = '0;
        gpio_six_out = 1'b0;
        gpio_six_oe_n = 1'b0;
        error_cnt = 0;
        check_count = 0;
        crc_pulses = 0;
        HOST.wait_clk(16);
        nrst = 1'b1;
        HOST.wait_clk(4);
        chk_bit("six pass", 1'b0, general_pin_six_oe_n);
        t_reset();
        t_stream();
        t_regs();
        t_ready();
        t_drive();
        t_release();
        conclude();
    end

    // The scenarios need about 360 us; a hang is cut off at 1 ms.
    initial begin
        #1_000_000;
        error_cnt++;
        conclude();
    end
endmodule : afe_spi_interface_control_test
`default_nettype wire

// ===== tb/spi_host_model.sv
// Behavioural serial master that frames register accesses in clock mode 3.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk,
    input wire logic sdo_pin,
    output logic sclk,
    output logic chip_select_n,
    output logic sdi
);
    localparam int HALF = 6;

    // Park the clock high and keep the slave deselected until a frame starts.
    initial begin
        sclk = 1'b1;
        chip_select_n = 1'b1;
        sdi = 1'b1;
    end

    // Pins move 1 ns after a core edge, never on it.
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // A full phase of setup on select keeps the synchroniser well ahead.
    task automatic select(input logic on);
        chip_select_n = ~on;
        wait_clk(HALF);
    endtask : select

    // Data leaves on the falling edge and the reply is taken at the rise.
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = tx[i];
            wait_clk(HALF);
            sclk = 1'b1;
            rx[i] = sdo_pin;
            wait_clk(HALF);
        end
        // The last bit is not held past its phase, so the line flips.
        sdi = ~tx[0];
    endtask : shift_byte
endmodule : spi_host_model
`default_nettype wire
